// ---- core/ptpcc_pkg.sv ----
// package for the ptp clock control block: register indices, field positions,
// reset values, timing counts and the shared types.
// assumes a 250 MHz hclk and a 32-bit ahb-lite register bus.
`default_nettype none
package ptpcc_pkg;
   // register indices; byte address is four times the index
   localparam logic [11:0] IDX_CTRL = 12'h500;
   localparam logic [11:0] IDX_PHASE = 12'h502;
   localparam logic [11:0] IDX_NS_HI = 12'h504;
   localparam logic [11:0] IDX_NS_LO = 12'h506;
   localparam logic [11:0] IDX_SEC_HI = 12'h508;
   localparam logic [11:0] IDX_SEC_LO = 12'h50a;
   localparam logic [11:0] IDX_RATE_HI = 12'h50c;
   localparam logic [11:0] IDX_RATE_LO = 12'h50e;
   // control register fields
   localparam int CTRL_FREQ_DIS = 15;
   localparam int CTRL_STEP = 6;
   localparam int CTRL_STEP_DIR = 5;
   localparam int CTRL_READ = 4;
   localparam int CTRL_LOAD = 3;
   localparam int CTRL_CONT = 2;
   localparam int CTRL_EN = 1;
   localparam int CTRL_RST = 0;
   localparam logic [15:0] CTRL_MASK = 16'h807f;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   // rate high word fields
   localparam int RATE_SIGN = 15;
   localparam int RATE_TEMP = 14;
   localparam logic [15:0] RATE_HI_MASK = 16'h3fff;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [2:0] PHASE_RESET = 3'h0;
   localparam logic [2:0] PHASE_MAX = 3'h4;
   // timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int TICK_NS = 40;
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam logic [3:0] DIV_LAST = 4'(TICK_CYCLES - 1);
   localparam logic [3:0] DIV_RESET = 4'h0;
   localparam logic [7:0] NS_PER_TICK = 8'(TICK_NS);
   localparam logic [32:0] NS_PER_SEC = 33'h03b9aca00;

   typedef struct packed {
      logic [31:0] sec;
      logic [31:0] ns;
   } ptpcc_time_t;

   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_WRITE,
      BUS_READ
   } ptpcc_bus_state_t;

   typedef struct packed {
      ptpcc_bus_state_t bus;
      logic [11:0] idx;
      logic hit;
      logic ready;
      logic [31:0] rdata;
      logic [15:0] ctrl;
      logic [2:0] phase;
      logic [15:0] ns_hi;
      logic [15:0] ns_lo;
      logic [15:0] sec_hi;
      logic [15:0] sec_lo;
      logic [15:0] rate_hi;
      logic [15:0] rate_lo;
      logic [3:0] div;
      ptpcc_time_t now;
      logic [29:0] frac;
      logic tick;
      logic follow;
      logic corr_pulse;
      logic corr_up;
   } ptpcc_state_t;
endpackage : ptpcc_pkg
`default_nettype wire

// ---- core/ptpcc_time_alu.sv ----
// seconds/nanoseconds adder-subtractor for the ptp clock.
// assumes both nanosecond inputs are already below one second.
`default_nettype none
module ptpcc_time_alu (
   input wire ptpcc_pkg::ptpcc_time_t a,
   input wire ptpcc_pkg::ptpcc_time_t d,
   input wire logic add,
   output ptpcc_pkg::ptpcc_time_t r
);
   logic [32:0] ns_sum;
   logic [32:0] ns_fix;

   // nanoseconds wrap at one billion with a carry or borrow into seconds
   always_comb begin
      ns_sum = {1'b0, a.ns} + {1'b0, d.ns};
      ns_fix = ns_sum - ptpcc_pkg::NS_PER_SEC;
      r.sec = a.sec;
      r.ns = a.ns;
      if (add) begin
         if (ns_sum >= ptpcc_pkg::NS_PER_SEC) begin
            r.ns = ns_fix[31:0];
            r.sec = a.sec + d.sec + 32'h1;
         end else begin
            r.ns = ns_sum[31:0];
            r.sec = a.sec + d.sec;
         end
      end else begin
         if (a.ns >= d.ns) begin
            r.ns = a.ns - d.ns;
            r.sec = a.sec - d.sec;
         end else begin
            // borrow one second; add before subtract so nothing underflows
            r.ns = 32'(({1'b0, a.ns} + ptpcc_pkg::NS_PER_SEC) - {1'b0, d.ns});
            r.sec = a.sec - d.sec - 32'h1;
         end
      end
   end
endmodule : ptpcc_time_alu
`default_nettype wire

// ---- core/ptpcc_clock_control.sv ----
// ptp real-time clock control: registers, time keeping and commands.
// assumes a single ahb-lite master, 250 MHz hclk, word accesses only.
`default_nettype none
module ptpcc_clock_control (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output ptpcc_pkg::ptpcc_time_t rtc_time,
   output logic rtc_tick,
   output logic timer_follow_adj,
   output logic timer_corr_pulse,
   output logic timer_corr_up
);
   ptpcc_pkg::ptpcc_state_t s;
   ptpcc_pkg::ptpcc_state_t next_s;
   ptpcc_pkg::ptpcc_time_t alu_d;
   ptpcc_pkg::ptpcc_time_t alu_r;
   ptpcc_pkg::ptpcc_time_t staged;
   logic alu_add;
   logic tick_now;
   logic [30:0] frac_sum;
   logic [30:0] frac_diff;
   logic [29:0] rate;
   logic rate_up;
   logic frac_carry;
   logic [7:0] tick_ns;

   // register read mux; reserved and unmapped bits read as zero
   function automatic logic [31:0] read_reg(input ptpcc_pkg::ptpcc_state_t st,
                                            input logic [11:0] idx);
      logic [15:0] v;
      v = 16'h0000;
      unique case (idx)
         ptpcc_pkg::IDX_CTRL: v = st.ctrl & ptpcc_pkg::CTRL_MASK;
         ptpcc_pkg::IDX_PHASE: v = {13'h0000, st.phase};
         ptpcc_pkg::IDX_NS_HI: v = st.ns_hi;
         ptpcc_pkg::IDX_NS_LO: v = st.ns_lo;
         ptpcc_pkg::IDX_SEC_HI: v = st.sec_hi;
         ptpcc_pkg::IDX_SEC_LO: v = st.sec_lo;
         ptpcc_pkg::IDX_RATE_HI: v = st.rate_hi;
         ptpcc_pkg::IDX_RATE_LO: v = st.rate_lo;
         default: v = 16'h0000;
      endcase
      return {16'h0000, v};
   endfunction : read_reg

   // word-sized access inside the low 16 kbyte window counts as a hit
   function automatic logic addr_hit(input logic [31:0] addr, input logic [2:0] size);
      return (addr[31:14] == 18'h00000) && (addr[1:0] == 2'h0) && (size == 3'h2);
   endfunction : addr_hit

   // staged time value assembled from the holding words
   assign staged.sec = {s.sec_hi, s.sec_lo};
   assign staged.ns = {s.ns_hi, s.ns_lo};

   // fractional rate accumulator; a wrap gives one extra or one missing ns
   assign rate = {s.rate_hi[13:0], s.rate_lo};
   assign rate_up = s.rate_hi[ptpcc_pkg::RATE_SIGN];
   assign frac_sum = {1'b0, s.frac} + {1'b0, rate};
   assign frac_diff = {1'b0, s.frac} - {1'b0, rate};
   assign frac_carry = s.ctrl[ptpcc_pkg::CTRL_CONT] &
                       (rate_up ? frac_sum[30] : frac_diff[30]);
   assign tick_now = (s.div == ptpcc_pkg::DIV_LAST);

   // per-tick advance: forty ns, nudged by one when the fraction wraps
   always_comb begin
      tick_ns = ptpcc_pkg::NS_PER_TICK;
      if (frac_carry) begin
         if (rate_up) begin
            tick_ns = ptpcc_pkg::NS_PER_TICK + 8'h01;
         end else begin
            tick_ns = ptpcc_pkg::NS_PER_TICK - 8'h01;
         end
      end
   end

   // one shared adder: tick cycles advance, other cycles serve a step
   always_comb begin
      if (tick_now) begin
         alu_d.sec = 32'h00000000;
         alu_d.ns = {24'h000000, tick_ns};
         alu_add = 1'b1;
      end else begin
         alu_d = staged;
         alu_add = s.ctrl[ptpcc_pkg::CTRL_STEP_DIR];
      end
   end

   ptpcc_time_alu u_alu (
      .a(s.now),
      .d(alu_d),
      .add(alu_add),
      .r(alu_r)
   );

   // next-state logic: time engine first, then the bus, so writes win
   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      next_s.corr_pulse = 1'b0;

      // 25 MHz divider; its position is the 8 ns sub-cycle phase
      if (tick_now) begin
         next_s.div = ptpcc_pkg::DIV_RESET;
      end else begin
         next_s.div = s.div + 4'h1;
      end

      // commands wait for a non-tick cycle so the advance is never lost
      if (tick_now) begin
         next_s.tick = 1'b1;
         if (s.ctrl[ptpcc_pkg::CTRL_EN]) begin
            next_s.now = alu_r;
            if (s.ctrl[ptpcc_pkg::CTRL_CONT]) begin
               next_s.frac = rate_up ? frac_sum[29:0] : frac_diff[29:0];
            end
            // switch timers see corrections only while following is on
            next_s.corr_pulse = frac_carry & ~s.ctrl[ptpcc_pkg::CTRL_FREQ_DIS];
            next_s.corr_up = rate_up;
         end
      end else if (s.ctrl[ptpcc_pkg::CTRL_RST]) begin
         next_s.now.sec = 32'h00000000;
         next_s.now.ns = 32'h00000000;
         next_s.frac = 30'h00000000;
         next_s.ctrl[ptpcc_pkg::CTRL_RST] = 1'b0;
      end else if (s.ctrl[ptpcc_pkg::CTRL_LOAD]) begin
         next_s.now = staged;
         // an invalid phase code loads as slot zero
         if (s.phase <= ptpcc_pkg::PHASE_MAX) begin
            next_s.div = {s.phase, 1'b0};
         end else begin
            next_s.div = ptpcc_pkg::DIV_RESET;
         end
         next_s.ctrl[ptpcc_pkg::CTRL_LOAD] = 1'b0;
      end else if (s.ctrl[ptpcc_pkg::CTRL_STEP]) begin
         next_s.now = alu_r;
         next_s.ctrl[ptpcc_pkg::CTRL_STEP] = 1'b0;
      end else if (s.ctrl[ptpcc_pkg::CTRL_READ]) begin
         next_s.phase = s.div[3:1];
         next_s.ns_hi = s.now.ns[31:16];
         next_s.ns_lo = s.now.ns[15:0];
         next_s.sec_hi = s.now.sec[31:16];
         next_s.sec_lo = s.now.sec[15:0];
         next_s.ctrl[ptpcc_pkg::CTRL_READ] = 1'b0;
      end

      next_s.follow = ~s.ctrl[ptpcc_pkg::CTRL_FREQ_DIS];

      // write data phase; a new command bit set here wins over its clear
      if (s.bus == ptpcc_pkg::BUS_WRITE && s.hit) begin
         unique case (s.idx)
            ptpcc_pkg::IDX_CTRL: begin
               next_s.ctrl = (hwdata[15:0] & ptpcc_pkg::CTRL_MASK) |
                             (next_s.ctrl & 16'h0059);
            end
            ptpcc_pkg::IDX_PHASE: next_s.phase = hwdata[2:0];
            ptpcc_pkg::IDX_NS_HI: next_s.ns_hi = hwdata[15:0];
            ptpcc_pkg::IDX_NS_LO: next_s.ns_lo = hwdata[15:0];
            ptpcc_pkg::IDX_SEC_HI: next_s.sec_hi = hwdata[15:0];
            ptpcc_pkg::IDX_SEC_LO: next_s.sec_lo = hwdata[15:0];
            ptpcc_pkg::IDX_RATE_HI: next_s.rate_hi = hwdata[15:0];
            ptpcc_pkg::IDX_RATE_LO: next_s.rate_lo = hwdata[15:0];
            default: next_s.ctrl = next_s.ctrl;
         endcase
      end

      // read data phase: one wait state so hrdata comes from a flop
      if (s.bus == ptpcc_pkg::BUS_READ) begin
         next_s.rdata = s.hit ? read_reg(s, s.idx) : 32'h00000000;
         next_s.ready = 1'b1;
      end

      // address phase
      next_s.bus = ptpcc_pkg::BUS_IDLE;
      if (hsel && hready && htrans[1]) begin
         next_s.idx = haddr[13:2];
         next_s.hit = addr_hit(haddr, hsize);
         if (hwrite) begin
            next_s.bus = ptpcc_pkg::BUS_WRITE;
         end else begin
            next_s.bus = ptpcc_pkg::BUS_READ;
            next_s.ready = 1'b0;
         end
      end
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s.bus <= ptpcc_pkg::BUS_IDLE;
         s.idx <= 12'h000;
         s.hit <= 1'b0;
         s.ready <= 1'b1;
         s.rdata <= 32'h00000000;
         s.ctrl <= ptpcc_pkg::CTRL_RESET;
         s.phase <= ptpcc_pkg::PHASE_RESET;
         s.ns_hi <= ptpcc_pkg::WORD_RESET;
         s.ns_lo <= ptpcc_pkg::WORD_RESET;
         s.sec_hi <= ptpcc_pkg::WORD_RESET;
         s.sec_lo <= ptpcc_pkg::WORD_RESET;
         s.rate_hi <= ptpcc_pkg::WORD_RESET;
         s.rate_lo <= ptpcc_pkg::WORD_RESET;
         s.div <= ptpcc_pkg::DIV_RESET;
         s.now <= 64'h0000000000000000;
         s.frac <= 30'h00000000;
         s.tick <= 1'b0;
         s.follow <= 1'b1;
         s.corr_pulse <= 1'b0;
         s.corr_up <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state flops; response is always okay
   assign hreadyout = s.ready;
   assign hresp = 1'b0;
   assign hrdata = s.rdata;
   assign rtc_time = s.now;
   assign rtc_tick = s.tick;
   assign timer_follow_adj = s.follow;
   assign timer_corr_pulse = s.corr_pulse;
   assign timer_corr_up = s.corr_up;
endmodule : ptpcc_clock_control
`default_nettype wire

// ---- test/ptpcc_chk.sv ----
// assertion checker for the ptp clock control top-level ports.
// assumes hready is tied to hreadyout by the bench.
`default_nettype none
module ptpcc_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [31:0] hwdata,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire ptpcc_pkg::ptpcc_time_t rtc_time,
   input wire logic rtc_tick,
   input wire logic timer_corr_pulse
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // accepted address phase
   wire logic acc = hsel && hready && htrans[1];
   logic ctrl_wr;
   logic [4:0] quiet;
   // a load re-phases the divider, so tick spacing goes unchecked around one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_wr <= 1'b0;
         quiet <= 5'h00;
      end else begin
         ctrl_wr <= acc && hwrite && (haddr[13:2] == ptpcc_pkg::IDX_CTRL);
         if (ctrl_wr && hwdata[ptpcc_pkg::CTRL_LOAD]) begin
            quiet <= 5'h18; // covers queued commands and a tick wait
         end else if (quiet != 5'h00) begin
            quiet <= quiet - 5'h01;
         end
      end
   end
   sequence s_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   // ten hclk per tick, split since repetition stays small
   sequence s_gap;
      (!rtc_tick)[*8] ##1 !rtc_tick ##1 rtc_tick;
   endsequence
   a_read_wait: assert property (acc && !hwrite |=> s_wait)
      else $error("read wait wrong");
   a_write_zero: assert property (acc && hwrite |=> hreadyout)
      else $error("write waited");
   a_resp_okay: assert property (!hresp)
      else $error("error response");
   a_rdata_upper: assert property (hrdata[31:16] == 16'h0000)
      else $error("read upper half set");
   a_rdata_hold: assert property ($changed(hrdata) |-> $rose(hreadyout))
      else $error("read data moved");
   a_tick_gap: assert property (disable iff (!hresetn || quiet != 5'h00) rtc_tick |=> s_gap)
      else $error("tick spacing wrong");
   a_ns_range: assert property (rtc_time.ns < 32'h3b9aca00)
      else $error("nanoseconds past one second");
   a_corr_tick: assert property (timer_corr_pulse |-> rtc_tick ##1 !timer_corr_pulse)
      else $error("correction off tick");
endmodule : ptpcc_chk
bind ptpcc_clock_control ptpcc_chk i_ptpcc_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .hwdata(hwdata),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .rtc_time(rtc_time), .rtc_tick(rtc_tick),
   .timer_corr_pulse(timer_corr_pulse));
`default_nettype wire

// ---- test/tb_top.sv ----
// self-checking bench for ptpcc_clock_control over ahb-lite.
// assumes zero-wait writes and one-wait reads as handed over.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic hreadyout, hresp, rtc_tick, follow, corr, corr_up;
   ptpcc_pkg::ptpcc_time_t rtc_time, a, b;
   logic [15:0] q;
   int failures = 0, total_checks = 0, corr_cnt = 0;
   ptpcc_clock_control i_ptpcc_clock_control (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .rtc_time(rtc_time), .rtc_tick(rtc_tick), .timer_follow_adj(follow),
      .timer_corr_pulse(corr), .timer_corr_up(corr_up));
   always #2 hclk = ~hclk;
   // count corrections seen by the timers
   always @(posedge hclk) if (corr === 1'b1) corr_cnt <= corr_cnt + 1;
   task ck(input string n, input logic [63:0] s, input logic [63:0] e);
      total_checks++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask : ck
   // one single transfer; holds each phase until hready is seen high
   task xf(input logic w, input logic [11:0] i, input logic [15:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {18'h0, i, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {16'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata[15:0];
   endtask : xf
   // wait for self-clearing command bits to drop
   task pl;
      for (int k = 0; k < 20; k++) begin
         xf(1'b0, ptpcc_pkg::IDX_CTRL, 16'h0);
         if ((q & 16'h0059) == 16'h0) break;
      end
      ck("cmd clear", q & 16'h0059, 64'h0);
   endtask : pl
   task tk(output ptpcc_pkg::ptpcc_time_t t);
      @(posedge hclk iff rtc_tick);
      #1 t = rtc_time;
   endtask : tk
   function automatic ptpcc_pkg::ptpcc_time_t nx(ptpcc_pkg::ptpcc_time_t t, int d);
      t.ns = t.ns + d;
      if (t.ns >= 32'h3b9aca00) begin
         t.ns = t.ns - 32'h3b9aca00;
         t.sec = t.sec + 1;
      end
      return t;
   endfunction : nx
   task ld(input logic [15:0] nh, input logic [15:0] nl, input logic [15:0] sl);
      xf(1'b1, ptpcc_pkg::IDX_NS_HI, nh);
      xf(1'b1, ptpcc_pkg::IDX_NS_LO, nl);
      xf(1'b1, ptpcc_pkg::IDX_SEC_LO, sl);
   endtask : ld
   task t_regs;
      xf(1'b0, ptpcc_pkg::IDX_CTRL, 16'h0);
      ck("ctrl reset", q, 64'h0);
      xf(1'b0, ptpcc_pkg::IDX_NS_HI, 16'h0);
      ck("ns hi reset", q, 64'h0);
      xf(1'b1, 12'h520, 16'hffff);
      xf(1'b0, 12'h520, 16'h0);
      ck("unmapped", q, 64'h0);
   endtask : t_regs
   task t_load_step;
      ld(16'h0001, 16'h2345, 16'h0007);
      xf(1'b1, ptpcc_pkg::IDX_CTRL, 16'h0008);
      pl;
      ck("load", rtc_time, {32'h7, 32'h12345});
      ld(16'h0, 16'h0064, 16'h0);
      xf(1'b1, ptpcc_pkg::IDX_CTRL, 16'h0060);
      pl;
      ck("step add", rtc_time, {32'h7, 32'h123a9});
      xf(1'b1, ptpcc_pkg::IDX_CTRL, 16'h0040);
      pl;
      ck("step sub", rtc_time, {32'h7, 32'h12345});
   endtask : t_load_step
   // run across the seconds boundary, forty ns each tick
   task t_run;
      ld(16'h3b9a, 16'hc988, 16'h0007); // three ticks short of the boundary
      xf(1'b1, ptpcc_pkg::IDX_CTRL, 16'h000a);
      pl;
      tk(a);
      for (int k = 0; k < 3; k++) begin
         tk(b);
         ck("advance", b, nx(a, 40));
         a = b;
      end
   endtask : t_run
   // rate of half a ns per tick: steps alternate
   task t_rate;
      xf(1'b1, ptpcc_pkg::IDX_RATE_HI, 16'ha000);
      xf(1'b1, ptpcc_pkg::IDX_RATE_LO, 16'h0);
      xf(1'b1, ptpcc_pkg::IDX_CTRL, 16'h0007);
      pl;
      tk(a);
      corr_cnt = 0;
      repeat (4) tk(b);
      ck("rate add", b, nx(a, 162));
      ck("corr seen", corr_cnt, 64'h2);
      ck("corr up", corr_up, 64'h1);
      ck("follow on", follow, 64'h1);
      xf(1'b1, ptpcc_pkg::IDX_RATE_HI, 16'h2000);
      xf(1'b1, ptpcc_pkg::IDX_CTRL, 16'h8006);
      tk(a);
      corr_cnt = 0;
      repeat (4) tk(b);
      ck("rate sub", b, nx(a, 158));
      ck("corr blocked", corr_cnt, 64'h0);
      ck("follow off", follow, 64'h0);
      ck("corr down", corr_up, 64'h0);
   endtask : t_rate
   // load a known time with the clock stopped, wipe the holding words, snapshot
   task t_snap;
      ld(16'h1234, 16'h5678, 16'h0009);
      xf(1'b1, ptpcc_pkg::IDX_CTRL, 16'h0008);
      pl;
      ld(16'h0, 16'h0, 16'h0);
      xf(1'b1, ptpcc_pkg::IDX_CTRL, 16'h0010);
      pl;
      xf(1'b0, ptpcc_pkg::IDX_NS_HI, 16'h0);
      ck("snap ns hi", q, 64'h1234);
      xf(1'b0, ptpcc_pkg::IDX_NS_LO, 16'h0);
      ck("snap ns lo", q, 64'h5678);
      xf(1'b0, ptpcc_pkg::IDX_SEC_LO, 16'h0);
      ck("snap sec", q, 64'h9);
      xf(1'b0, ptpcc_pkg::IDX_PHASE, 16'h0);
      ck("phase valid", q <= 16'h4, 64'h1);
      xf(1'b1, ptpcc_pkg::IDX_CTRL, 16'h0011);
      pl;
      ck("clock reset", rtc_time, 64'h0);
      xf(1'b0, ptpcc_pkg::IDX_NS_LO, 16'h0);
      ck("reset first", q, 64'h0);
   endtask : t_snap
   task results;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results
   // watchdog well beyond the few hundred cycles needed
   initial begin
      #60000;
      failures++;
      results;
   end
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs;
      t_load_step;
      t_run;
      t_rate;
      t_snap;
      results;
   end
endmodule : tb_top
`default_nettype wire
